/* src/scc_pkg.sv */
// scc_pkg: constants for the stepper coil serial control block
// assumes a 12-bit command/status word, msb first on the serial link
package scc_pkg;
   localparam int          CMD_W      = 12;
   localparam int          CMD_MSB    = 11;
   localparam logic [3:0]  CMD_BITS   = 4'hc;  // bits for a full word
   localparam logic [3:0]  CNT_ZERO   = 4'h0;
   localparam logic [3:0]  CNT_ONE    = 4'h1;
   // command fields
   localparam int          CMD_MDA    = 11;
   localparam int          CMD_CA_HI  = 10;
   localparam int          CMD_CA_LO  = 7;
   localparam int          CMD_PHA    = 6;
   localparam int          CMD_MDB    = 5;
   localparam int          CMD_CB_HI  = 4;
   localparam int          CMD_CB_LO  = 1;
   localparam int          CMD_PHB    = 0;
   localparam logic [11:0] CMD_RESET  = 12'h000;
   localparam logic [3:0]  MAG_OFF    = 4'h0;
   // status fields
   localparam int          ST_ONE     = 8;
   localparam int          ST_OT      = 7;
   localparam int          ST_PW      = 6;
   localparam int          ST_UV      = 5;
   localparam int          ST_HIGHSIDE_OVERCURRENT_FLAG    = 4;
   localparam int          ST_OLB     = 3;
   localparam int          ST_OLA     = 2;
   localparam int          ST_OCB     = 1;
   localparam int          ST_OCA     = 0;
   localparam logic [11:0] ST_BASE    = 12'h100;  // fixed bits 11..8
   // overcurrent source index
   localparam int          OC_A       = 0;
   localparam int          OC_B       = 1;
   localparam int          OC_HS      = 2;
   // detector limits
   localparam logic [1:0]  OC_HITS    = 2'h3;   // overcurrent cycles
   localparam logic [5:0]  OC_WINDOW  = 6'h3f;  // 63 chopper cycles
   localparam logic [3:0]  OL_LIMIT   = 4'he;   // count limit 14; raw flag set on the 15th oscillator tick
endpackage : scc_pkg

/* src/scc_serial_ctrl.sv */
// scc_serial_ctrl: serial command/status port of a two-coil stepper driver
// assumes serialClock stops while chipSelectN is high, and that the host
// waits three system clocks after chipSelectN falls and after it rises
`timescale 1ns/100ps
module scc_serial_ctrl
   import scc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic       serialClock,
   input  wire logic       chipSelectN,
   input  wire logic       serialDataIn,
   output logic            serialDataOut,
   output logic            serialDataOutEn,
   input  wire logic       driverEnableN,
   input  wire logic       serialModeSelect,
   input  wire logic       externalReferenceSelectN,
   input  wire logic       overTempIn,
   input  wire logic       preWarnIn,
   input  wire logic       supplyLowIn,
   input  wire logic       chopperCycle,
   input  wire logic [2:0] overcurrentIn,
   input  wire logic       oscTick,
   input  wire logic [1:0] targetReached,
   output logic            coilAMixedDecay,
   output logic [3:0]      coilACurrent,
   output logic            coilAPolarity,
   output logic            coilBMixedDecay,
   output logic [3:0]      coilBCurrent,
   output logic            coilBPolarity,
   output logic [1:0]      chopperOn,
   output logic [1:0]      slowDecayHold,
   output logic            lowPowerStandby,
   output logic            useExternalReference,
   output logic [11:0]     statusWord
);

   typedef struct packed {
      logic [1:0]      csSync;
      logic [1:0]      ennSync;
      logic [1:0]      modeSync;
      logic [1:0]      extSync;
      logic [2:0][1:0] envSync;
      logic            csPrev;
      logic [11:0]     command;
      logic [2:0]      ocFlag;
      logic [2:0][1:0] ocHits;
      logic [2:0][5:0] ocWin;
      logic [1:0]      olRaw;
      logic [1:0][3:0] olCount;
      logic [11:0]     snapshot;
   } scc_sys_type;

   typedef struct packed {
      logic [11:0] shift;
      logic        lengthOk;
   } scc_link_type;

   scc_sys_type  sys;
   scc_sys_type  next_sys;
   scc_link_type link;
   scc_link_type next_link;
   logic [3:0]   bitCount;
   logic         fallSeen;
   logic         outBit;
   logic [2:0]   ocTrip;
   logic [1:0]   olFlag;
   logic         active;
   logic         csRise;
   logic         bothOff;
   logic [11:0]  liveStatus;
   logic         anyFault;

   // one overcurrent window step: returns {hits, window, trip}
   function automatic logic [8:0] scc_oc_step(input logic [1:0] hits,
                                              input logic [5:0] win,
                                              input logic       ev);
      logic [1:0] h;
      logic [5:0] w;
      logic       t;
      h = hits;
      w = win;
      t = 1'b0;
      if (hits == 2'h0) begin
         if (ev) begin
            h = 2'h1;
            w = 6'h01;
         end
      end else begin
         w = win + 6'h01;
         if (ev) begin
            h = hits + 2'h1;
         end
         if (h == OC_HITS) begin
            t = 1'b1;
            h = 2'h0;
            w = 6'h00;
         end else if (w == OC_WINDOW) begin
            h = 2'h0;
            w = 6'h00;
         end
      end
      return {h, w, t};
   endfunction : scc_oc_step

   // ---------------- link domain (serial clock) ----------------

   // bit counter cleared while deselected, saturates at a full word
   always_ff @(posedge serialClock or posedge chipSelectN) begin
      if (chipSelectN) begin
         bitCount <= CNT_ZERO;
      end else if (bitCount != CMD_BITS) begin
         bitCount <= bitCount + CNT_ONE;
      end
   end

   // shift register; first rise loads the frozen status word
   always_comb begin
      next_link = link;
      if (bitCount == CNT_ZERO) begin
         next_link.shift = {sys.snapshot[CMD_MSB-1:0], serialDataIn};
         next_link.lengthOk = 1'b0;
      end else begin
         next_link.shift = {link.shift[CMD_MSB-1:0], serialDataIn};
      end
      if (bitCount == CMD_BITS - CNT_ONE) begin
         next_link.lengthOk = 1'b1;
      end
   end

   // register the link state on each rise
   always_ff @(posedge serialClock) begin
      link <= next_link;
   end

   // output bit changes after each falling edge
   always_ff @(negedge serialClock) begin
      outBit <= link.shift[CMD_MSB];
   end

   // marks that the first fall of the frame has passed
   always_ff @(negedge serialClock or posedge chipSelectN) begin
      if (chipSelectN) begin
         fallSeen <= 1'b0;
      end else begin
         fallSeen <= 1'b1;
      end
   end

   // before the first fall the status msb is shown directly
   assign serialDataOut = fallSeen ? outBit : sys.snapshot[CMD_MSB];

   // ---------------- system domain ----------------

   assign active  = !sys.ennSync[1] && sys.modeSync[1];
   assign csRise  = sys.csSync[1] && !sys.csPrev;
   assign bothOff = (coilACurrent == MAG_OFF) && (coilBCurrent == MAG_OFF);

   // any fault: the overcurrent flags or the second synchroniser flops of the environment inputs
   assign anyFault = (|sys.ocFlag) || sys.envSync[2][1]
                     || sys.envSync[1][1] || sys.envSync[0][1];

   // open load: raw timeout or any fault, never with zero magnitude
   always_comb begin
      olFlag[0] = (sys.olRaw[0] || anyFault)
                  && (coilACurrent != MAG_OFF);
      olFlag[1] = (sys.olRaw[1] || anyFault)
                  && (coilBCurrent != MAG_OFF);
   end

   // live status word
   always_comb begin
      liveStatus          = ST_BASE;
      liveStatus[ST_OT]   = sys.envSync[2][1];
      liveStatus[ST_PW]   = sys.envSync[1][1];
      liveStatus[ST_UV]   = sys.envSync[0][1];
      liveStatus[ST_HIGHSIDE_OVERCURRENT_FLAG] = sys.ocFlag[OC_HS];
      liveStatus[ST_OLB]  = olFlag[1];
      liveStatus[ST_OLA]  = olFlag[0];
      liveStatus[ST_OCB]  = sys.ocFlag[OC_B];
      liveStatus[ST_OCA]  = sys.ocFlag[OC_A];
   end

   // next state of the system domain
   always_comb begin
      logic [8:0] step;
      next_sys = sys;
      ocTrip = 3'h0;
      step = 9'h000;
      // two-flop synchronisers
      next_sys.csSync   = {sys.csSync[0], chipSelectN};
      next_sys.ennSync  = {sys.ennSync[0], driverEnableN};
      next_sys.modeSync = {sys.modeSync[0], serialModeSelect};
      next_sys.extSync  = {sys.extSync[0], externalReferenceSelectN};
      next_sys.envSync[2] = {sys.envSync[2][0], overTempIn};
      next_sys.envSync[1] = {sys.envSync[1][0], preWarnIn};
      next_sys.envSync[0] = {sys.envSync[0][0], supplyLowIn};
      next_sys.csPrev = sys.csSync[1];
      // overcurrent windows, one per source
      for (int i = 0; i < 3; i++) begin
         if (chopperCycle) begin
            step = scc_oc_step(sys.ocHits[i], sys.ocWin[i],
                               overcurrentIn[i]);
            next_sys.ocHits[i] = step[8:7];
            next_sys.ocWin[i]  = step[6:1];
            ocTrip[i]          = step[0];
         end
      end
      // open load timeout per coil
      for (int c = 0; c < 2; c++) begin
         if (targetReached[c] || !chopperOn[c]) begin
            next_sys.olCount[c] = CNT_ZERO;
            next_sys.olRaw[c]   = 1'b0;
         end else if (chopperCycle) begin
            next_sys.olCount[c] = CNT_ZERO;
         end else if (oscTick) begin
            if (sys.olCount[c] == OL_LIMIT) begin
               next_sys.olRaw[c] = 1'b1;
            end else begin
               next_sys.olCount[c] = sys.olCount[c] + CNT_ONE;
            end
         end
      end
      // zero on both coils clears flags; a new trip still wins
      next_sys.ocFlag = (bothOff ? 3'h0 : sys.ocFlag) | ocTrip;
      // command taken on select rise only for a full word
      if (csRise && link.lengthOk && active) begin
         next_sys.command = link.shift;
      end
      // status frozen while a frame may be running
      if (sys.csSync[1]) begin
         next_sys.snapshot = liveStatus;
      end
      // disable clears command, overcurrent and open load state; synchronisers, csPrev and snapshot are kept
      if (sys.ennSync[1]) begin
         next_sys.command = CMD_RESET;
         next_sys.ocFlag  = 3'h0;
         next_sys.ocHits  = '0;
         next_sys.ocWin   = '0;
         next_sys.olRaw   = 2'h0;
         next_sys.olCount = '0;
      end
      if (srst) begin
         next_sys = '0;
         next_sys.csSync   = 2'h3;
         next_sys.ennSync  = 2'h3;
         next_sys.extSync  = 2'h3;
         next_sys.csPrev   = 1'b1;
         next_sys.snapshot = ST_BASE;
      end
   end

   // register the system state
   always_ff @(posedge clock) begin
      sys <= next_sys;
   end

   // command field decode
   assign coilAMixedDecay = sys.command[CMD_MDA];
   assign coilACurrent    = sys.command[CMD_CA_HI:CMD_CA_LO];
   assign coilAPolarity   = sys.command[CMD_PHA];
   assign coilBMixedDecay = sys.command[CMD_MDB];
   assign coilBCurrent    = sys.command[CMD_CB_HI:CMD_CB_LO];
   assign coilBPolarity   = sys.command[CMD_PHB];

   // chopper and reference control
   assign slowDecayHold[0] = (coilACurrent == MAG_OFF);
   assign slowDecayHold[1] = (coilBCurrent == MAG_OFF);
   assign chopperOn[0] = !slowDecayHold[0];
   assign chopperOn[1] = !slowDecayHold[1];
   assign lowPowerStandby = bothOff || sys.ennSync[1];
   assign useExternalReference = !sys.extSync[1];
   assign statusWord = sys.snapshot;

   // output drives only while selected and enabled
   assign serialDataOutEn = active && !sys.csSync[1];

   // ---------------- checks ----------------

   cmd_capture_a: assert property (@(posedge clock) disable iff (srst)
      (csRise && link.lengthOk && active && !sys.ennSync[1])
      |=> sys.command == $past(link.shift))
      else $error("command not taken on select rise");

   short_frame_a: assert property (@(posedge clock) disable iff (srst)
      (csRise && !link.lengthOk && !sys.ennSync[1])
      |=> $stable(sys.command))
      else $error("short frame changed command");

   fixed_bits_a: assert property (@(posedge clock) disable iff (srst)
      sys.snapshot[CMD_MSB:ST_ONE] == ST_BASE[CMD_MSB:ST_ONE])
      else $error("fixed status bits wrong");

   zero_mag_ol_a: assert property (@(posedge clock) disable iff (srst)
      (coilACurrent == MAG_OFF) |-> !liveStatus[ST_OLA] && !chopperOn[0])
      else $error("open load with zero magnitude");

   zero_mag_olb_a: assert property (@(posedge clock) disable iff (srst)
      (coilBCurrent == MAG_OFF) |-> !liveStatus[ST_OLB] && !chopperOn[1])
      else $error("open load b with zero magnitude");

   ol_timeout_a: assert property (@(posedge clock) disable iff (srst)
      (oscTick && chopperOn[0] && !targetReached[0] && !chopperCycle
       && sys.olCount[0] == OL_LIMIT && !sys.ennSync[1]) |=> sys.olRaw[0])
      else $error("open load timeout not flagged");

   snapshot_hold_a: assert property (@(posedge clock) disable iff (srst)
      !sys.csSync[1] |=> $stable(sys.snapshot))
      else $error("status changed during a frame");

   standby_out_a: assert property (@(posedge clock) disable iff (srst)
      bothOff |-> lowPowerStandby && chopperOn == 2'b00)
      else $error("standby not entered");

   disable_clr_a: assert property (@(posedge clock) disable iff (srst)
      sys.ennSync[1] |=> sys.command == CMD_RESET && sys.ocFlag == 3'h0)
      else $error("disable did not clear registers");

   standby_clr_a: assert property (@(posedge clock) disable iff (srst)
      (bothOff && ocTrip == 3'h0) |=> sys.ocFlag == 3'h0)
      else $error("overcurrent flags not cleared");

   tristate_a: assert property (@(posedge clock) disable iff (srst)
      (sys.csSync[1] || sys.ennSync[1]) |-> !serialDataOutEn)
      else $error("output driven while deselected");

   oc_trip_a: assert property (@(posedge clock) disable iff (srst)
      (|ocTrip) && !sys.ennSync[1]
      |=> (sys.ocFlag & $past(ocTrip)) == $past(ocTrip))
      else $error("overcurrent trip lost");

   daisy_a: assert property (@(posedge serialClock) disable iff (chipSelectN)
      (bitCount != CNT_ZERO) |-> link.shift[0] == $past(serialDataIn))
      else $error("serial input not shifted in");

   frame_cov: cover property (@(posedge clock) disable iff (srst)
      csRise && link.lengthOk && active);
   short_cov: cover property (@(posedge clock) disable iff (srst)
      csRise && !link.lengthOk);
   trip_cov: cover property (@(posedge clock) disable iff (srst)
      |ocTrip);
   openload_cov: cover property (@(posedge clock) disable iff (srst)
      |sys.olRaw);
   standby_cov: cover property (@(posedge clock) disable iff (srst)
      csRise && bothOff);

endmodule : scc_serial_ctrl

/* verif/scc_host_model.sv */
// scc_host_model: serial master on the far side of the command port
// assumes the bench calls frame() and feeds back the resolved data line
`timescale 1ns/100ps
module scc_host_model (
   output logic      serialClock,
   output logic      chipSelectN,
   output logic      serialDataIn,
   input  wire logic serialDataLine
);
   // link clock stands still low and select high between frames
   initial begin
      serialClock  = 1'b0;
      chipSelectN  = 1'b1;
      serialDataIn = 1'b0;
   end
   // one frame of nBits at 64 ns per bit, msb first, line read at each rise
   task automatic frame(input logic [23:0] tx, input int nBits,
                        output logic [23:0] rx);
      rx = 24'h0;
      chipSelectN = 1'b0;
      #400;  // lets the status snapshot freeze first
      for (int i = nBits - 1; i >= 0; i--) begin
         serialDataIn = tx[i];
         #32 serialClock = 1'b1;
         rx = {rx[22:0], serialDataLine};
         #32 serialClock = 1'b0;
      end
      #32 chipSelectN = 1'b1;
      serialDataIn = ~serialDataIn;  // released line does not hold its value
      #400;
   endtask : frame
endmodule : scc_host_model

/* verif/test_stepper_coil_serial_control.sv */
// test_stepper_coil_serial_control: directed bench for scc_serial_ctrl
// assumes scc_host_model drives the link and the bench drives all else
`timescale 1ns/100ps
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin nErrors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_stepper_coil_serial_control
   import scc_pkg::*;
;
   logic clock = 1'b0, srst = 1'b1, driverEnableN = 1'b0, modeSel = 1'b1;
   logic extRefN = 1'b1, overTemp = 1'b0, preWarn = 1'b0, supLow = 1'b0;
   logic chopCyc = 1'b0, oscTick = 1'b0, sdoLast = 1'b0;
   logic [2:0] ocIn = 3'h0;
   logic [1:0] tgt = 2'h0, chopOn, slowHold;
   logic sck, csN, sdi, sdo, sdoEn, sdoWire, coil_a_mixed_decay, polA, coil_b_mixed_decay, polB, lowPwr;
   logic useExt;
   logic [3:0] curA, curB;
   logic [11:0] status;
   logic [23:0] rx;
   int nErrors = 0, nChecks = 0;
   // system clock at 10 MHz
   always #50 clock = ~clock;
   // undriven data line shows the inverse of its last driven value
   always @(sdo or sdoEn) if (sdoEn) sdoLast = sdo;
   assign sdoWire = sdoEn ? sdo : ~sdoLast;
   scc_host_model host (.serialClock(sck), .chipSelectN(csN),
      .serialDataIn(sdi), .serialDataLine(sdoWire));
   scc_serial_ctrl dut (.clock(clock), .srst(srst), .serialClock(sck),
      .chipSelectN(csN), .serialDataIn(sdi), .serialDataOut(sdo),
      .serialDataOutEn(sdoEn), .driverEnableN(driverEnableN),
      .serialModeSelect(modeSel), .externalReferenceSelectN(extRefN),
      .overTempIn(overTemp), .preWarnIn(preWarn), .supplyLowIn(supLow),
      .chopperCycle(chopCyc), .overcurrentIn(ocIn), .oscTick(oscTick),
      .targetReached(tgt), .coilAMixedDecay(coil_a_mixed_decay), .coilACurrent(curA),
      .coilAPolarity(polA), .coilBMixedDecay(coil_b_mixed_decay), .coilBCurrent(curB),
      .coilBPolarity(polB), .chopperOn(chopOn), .slowDecayHold(slowHold),
      .lowPowerStandby(lowPwr), .useExternalReference(useExt),
      .statusWord(status));
   // inputs change 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   // one full command frame, then time for the command to land
   task automatic send(input logic [11:0] c);
      host.frame({12'h000, c}, 12, rx);
      tick(5);
   endtask : send
   // decoded command fields against an expected word
   task automatic chkCmd(input logic [11:0] c);
      `CHK("mixA", c[CMD_MDA], coil_a_mixed_decay)
      `CHK("curA", c[CMD_CA_HI:CMD_CA_LO], curA)
      `CHK("polA", c[CMD_PHA], polA)
      `CHK("mixB", c[CMD_MDB], coil_b_mixed_decay)
      `CHK("curB", c[CMD_CB_HI:CMD_CB_LO], curB)
      `CHK("polB", c[CMD_PHB], polB)
   endtask : chkCmd
   // one chopper period start with the given overcurrent sources
   task automatic chop(input logic [2:0] oc);
      chopCyc = 1'b1;
      ocIn = oc;
      tick(1);
      chopCyc = 1'b0;
      ocIn = 3'h0;
      tick(1);
   endtask : chop
   // a run of oscillator ticks
   task automatic osc(input int n);
      repeat (n) begin
         oscTick = 1'b1;
         tick(1);
         oscTick = 1'b0;
         tick(1);
      end
   endtask : osc
   // prints the counts and the verdict, then stops
   task automatic summarize;
      $display("checks %0d mismatches %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   // watchdog at 2 ms, well beyond the few tens of microseconds of tests
   initial begin
      #2000000;
      nErrors++;
      summarize();
   end
   // main sequence
   initial begin
      tick(16);
      srst = 1'b0;
      tick(4);
      `CHK("rstStatus", 12'h100, status)
      `CHK("rstOutEn", 1'b0, sdoEn)
      chkCmd(12'h000);
      $display("test reset done");
      send(12'hb5a);
      `CHK("rxStatus", 12'h100, rx[11:0])
      chkCmd(12'hb5a);
      `CHK("chopOn", 2'b11, chopOn)
      host.frame(24'h000000, 11, rx);
      tick(5);
      chkCmd(12'hb5a);
      $display("test command done");
      host.frame(24'h3c74e1, 24, rx);
      tick(5);
      `CHK("daisyOut", 12'h3c7, rx[11:0])
      chkCmd(12'h4e1);
      `CHK("chopOnB0", 2'b01, chopOn)
      `CHK("slowHoldB0", 2'b10, slowHold)
      $display("test daisy done");
      send(12'hb5a);
      {overTemp, preWarn, supLow} = 3'b111;
      tick(4);
      `CHK("faultStatus", 12'h1ec, status)
      send(12'hb5a);
      `CHK("faultRx", 12'h1ec, rx[11:0])
      {overTemp, preWarn, supLow} = 3'b000;
      tick(4);
      `CHK("faultGone", 12'h100, status)
      $display("test faults done");
      chop(3'h7);
      chop(3'h7);
      `CHK("ocTwo", 12'h100, status)
      chop(3'h7);
      `CHK("ocThree", 12'h11f, status)
      send(12'h041);
      `CHK("standby", 1'b1, lowPwr)
      `CHK("chopOff", 2'b00, chopOn)
      send(12'hb5a);
      `CHK("ocCleared", 12'h100, status)
      $display("test overcurrent done");
      chop(3'h0);
      osc(15);
      `CHK("openLoad", 12'h10c, status)
      tgt = 2'b11;
      tick(1);
      tgt = 2'b00;
      tick(2);
      `CHK("olCleared", 12'h100, status)
      send(12'h01a);
      chop(3'h0);
      osc(15);
      `CHK("olMaskA", 12'h108, status)
      tgt = 2'b11;
      tick(1);
      tgt = 2'b00;
      $display("test open load done");
      extRefN = 1'b0;
      tick(4);
      `CHK("extRef", 1'b1, useExt)
      extRefN = 1'b1;
      tick(4);
      `CHK("intRef", 1'b0, useExt)
      modeSel = 1'b0;
      tick(4);
      send(12'hfff);
      chkCmd(12'h01a);
      modeSel = 1'b1;
      driverEnableN = 1'b1;
      tick(4);
      chkCmd(12'h000);
      `CHK("offStandby", 1'b1, lowPwr)
      send(12'hb5a);
      chkCmd(12'h000);
      `CHK("offOutEn", 1'b0, sdoEn)
      driverEnableN = 1'b0;
      tick(4);
      $display("test modes done");
      summarize();
   end
endmodule : test_stepper_coil_serial_control
